// ---- common/cfgflt_pkg.sv ----
// Purpose: Shared constants for the configuration-space fault capture block.
// Assumes: 32-bit AXI4-Lite register bus, one system clock.
// Notes:   Offsets are byte addresses; each register is one aligned word.
package cfgflt_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_FAULT_ADDR   = 8'h00;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR        = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h10;
  localparam logic [7:0] OFS_CTRL         = 8'h14;
  localparam logic [7:0] OFS_RGN_BASE0    = 8'h20;
  localparam logic [7:0] OFS_RGN_LIMIT0   = 8'h24;
  localparam logic [7:0] OFS_RGN_STRIDE   = 8'h08;

  // Fault status field positions.
  localparam int FS_USR_EXEC_POS  = 0;
  localparam int FS_USR_WRITE_POS = 1;
  localparam int FS_USR_READ_POS  = 2;
  localparam int FS_SUP_EXEC_POS  = 3;
  localparam int FS_SUP_WRITE_POS = 4;
  localparam int FS_SUP_READ_POS  = 5;
  localparam int FS_LOCAL_POS     = 7;
  localparam int FS_ORIG_LO_POS   = 8;
  localparam int FS_ORIG_LO_W     = 3;
  localparam int FS_ORIG_HI_POS   = 12;
  localparam int FS_ORIG_HI_W     = 4;
  localparam int ORIG_W           = 7;

  // Clear register and control register fields.
  localparam int CLR_POS       = 0;
  localparam int CTRL_EN_POS   = 0;
  localparam int CTRL_RGN_POS  = 8;

  // Interrupt status bits.
  localparam int IRQ_CAPT_POS  = 0;
  localparam int IRQ_LOST_POS  = 1;
  localparam int IRQ_W         = 2;

  // Reset values.
  localparam logic [31:0]      RST_FAULT_ADDR   = 32'h0000_0000;
  localparam logic [31:0]      RST_FAULT_STATUS = 32'h0000_0000;
  localparam logic [31:0]      RST_CTRL         = 32'h0000_0001;
  localparam logic [31:0]      RST_RGN          = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ          = 2'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Access kinds on the observed bus.
  localparam logic [1:0] KIND_READ  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_EXEC  = 2'h3;

  typedef enum logic [0:0]
  {
    CFGFLT_ARMED = 1'b0,
    CFGFLT_HELD  = 1'b1
  } cfgflt_state_e;

endpackage

// ---- hdl/cfgflt_axil.sv ----
// Purpose: AXI4-Lite slave front end for the fault capture registers.
// Assumes: Single outstanding write and read; user side answers reads combinationally.
// Notes:   Write address and data are taken in either order and applied together.
`timescale 1ns/10ps
module cfgflt_axil
  import cfgflt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // Write channels
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  // Read channels
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // Register side
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [31:0]            o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_err,
  output logic                   o_rd_en,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [31:0]       i_rd_data,
  input  wire logic              i_rd_err
);

  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  assign o_awready = !aw_held_q && !o_bvalid;
  assign o_wready  = !w_held_q && !o_bvalid;
  assign o_wr_en   = aw_held_q && w_held_q;
  assign o_wr_addr = aw_addr_q;
  assign o_wr_data = w_data_q;
  assign o_wr_strb = w_strb_q;
  assign o_arready = !o_rvalid;
  assign o_rd_en   = i_arvalid && o_arready;
  assign o_rd_addr = i_araddr;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (o_wr_en)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= i_wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end
    else if (o_rd_en)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= i_rd_data;
      o_rresp  <= i_rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_rready)
    begin
      o_rvalid <= 1'b0;
    end
  end

endmodule

// ---- hdl/cfgflt_rgn.sv ----
// Purpose: Matches an address against the reserved configuration regions.
// Assumes: Each region is an inclusive base to limit range.
// Notes:   A region with limit below base never matches.
`timescale 1ns/10ps
module cfgflt_rgn
#(
  parameter int N_RGN = 2
)
(
  // Region table
  input  wire logic [N_RGN-1:0][31:0] i_base,
  input  wire logic [N_RGN-1:0][31:0] i_limit,
  input  wire logic [N_RGN-1:0]       i_enable,
  // Probe
  input  wire logic [31:0]            i_addr,
  output logic                        o_hit
);

  logic [N_RGN-1:0] hit_vec;

  for (genvar g = 0; g < N_RGN; g++)
  begin : g_rgn
    assign hit_vec[g] = i_enable[g] && (i_addr >= i_base[g]) && (i_addr <= i_limit[g]);
  end

  assign o_hit = |hit_vec;

endmodule

// ---- hdl/cfgflt_top.sv ----
// Purpose: Protection of the configuration space with first-fault capture.
// Assumes: Observed accesses arrive as one-cycle strobes synchronous to i_sys_clk.
// Notes:   Only writes into an enabled reserved region count as violations.
// Behaviour
// - Writes into a reserved configuration region are flagged and raise an exception.
// - Only the first of several faults is captured until software clears it.
// - A series of faults yields a single exception; on the fault interrupt the capture bit fires once per series and the lost bit on its later faults.
// - After clearing, the next violation is captured and raises a fresh exception.
// - A software clear resets both fault address and fault status registers.
// - The captured faulting address is readable as a 32-bit value.
// - Fault status holds the originator identifier in the masked bit positions.
// - Fault status holds a flag telling whether local L1/L2 memory was involved.
// - Fault status holds separate supervisor read, write and execute flags.
// - Fault status holds separate user read, write and execute flags.
`timescale 1ns/10ps
module cfgflt_top
  import cfgflt_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int N_RGN  = 2
)
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,

  // AXI4-Lite write channels
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  output logic [1:0]             o_axi_bresp,

  // AXI4-Lite read channels
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,

  // Observed configuration-space accesses
  input  wire logic              i_acc_valid,
  input  wire logic [31:0]       i_acc_addr,
  input  wire logic [1:0]        i_acc_kind,
  input  wire logic              i_acc_super,
  input  wire logic              i_acc_local,
  input  wire logic [ORIG_W-1:0] i_acc_id,

  // Fault outputs
  output logic                   o_acc_deny,
  output logic                   o_fault_exc,
  output logic                   o_prot_fault_irq
);

  // Bus slave side signals.
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  // Capture state and registers.
  cfgflt_state_e     state_q;
  cfgflt_state_e     state_d;
  logic [31:0]       fault_addr_q;
  logic [31:0]       fault_stat_q;
  logic [31:0]       new_stat;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [31:0]       ctrl_q;
  logic [31:0]       bmask;

  // Region table.
  logic [N_RGN-1:0][31:0] rgn_base_q;
  logic [N_RGN-1:0][31:0] rgn_limit_q;
  logic [N_RGN-1:0]       rgn_en;
  logic [N_RGN-1:0]       rgn_base_rsel;
  logic [N_RGN-1:0]       rgn_limit_rsel;
  logic [N_RGN-1:0]       rgn_base_wsel;
  logic [N_RGN-1:0]       rgn_limit_wsel;
  logic [31:0]            rgn_rdata;
  logic                   rgn_hit;

  // Decode and event wires.
  logic wsel_clear;
  logic wsel_irq_stat;
  logic wsel_irq_mask;
  logic wsel_ctrl;
  logic rsel_fixed;
  logic clear_req;
  logic violation;
  logic capture;
  logic lost;

  cfgflt_axil #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_awvalid (i_axi_awvalid),
    .o_awready (o_axi_awready),
    .i_awaddr  (i_axi_awaddr),
    .i_wvalid  (i_axi_wvalid),
    .o_wready  (o_axi_wready),
    .i_wdata   (i_axi_wdata),
    .i_wstrb   (i_axi_wstrb),
    .o_bvalid  (o_axi_bvalid),
    .i_bready  (i_axi_bready),
    .o_bresp   (o_axi_bresp),
    .i_arvalid (i_axi_arvalid),
    .o_arready (o_axi_arready),
    .i_araddr  (i_axi_araddr),
    .o_rvalid  (o_axi_rvalid),
    .i_rready  (i_axi_rready),
    .o_rdata   (o_axi_rdata),
    .o_rresp   (o_axi_rresp),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  cfgflt_rgn #(
    .N_RGN (N_RGN)
  ) u_rgn (
    .i_base   (rgn_base_q),
    .i_limit  (rgn_limit_q),
    .i_enable (rgn_en),
    .i_addr   (i_acc_addr),
    .o_hit    (rgn_hit)
  );

  // Byte lanes expanded to a bit mask for partial writes.
  assign bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign wsel_clear    = wr_en && (wr_addr == ADDR_W'(OFS_CLEAR));
  assign wsel_irq_stat = wr_en && (wr_addr == ADDR_W'(OFS_IRQ_STATUS));
  assign wsel_irq_mask = wr_en && (wr_addr == ADDR_W'(OFS_IRQ_MASK));
  assign wsel_ctrl     = wr_en && (wr_addr == ADDR_W'(OFS_CTRL));
  assign rgn_en        = ctrl_q[CTRL_RGN_POS +: N_RGN];

  // Capture registers are read-only; writes to them are refused with an error.
  assign wr_err = wr_en && !(wsel_clear || wsel_irq_stat || wsel_irq_mask || wsel_ctrl
                  || (|rgn_base_wsel) || (|rgn_limit_wsel));

  for (genvar g = 0; g < N_RGN; g++)
  begin : g_rgn_reg
    localparam logic [7:0] BASE_OFS  = 8'(OFS_RGN_BASE0 + g * OFS_RGN_STRIDE);
    localparam logic [7:0] LIMIT_OFS = 8'(OFS_RGN_LIMIT0 + g * OFS_RGN_STRIDE);
    assign rgn_base_wsel[g]  = wr_en && (wr_addr == ADDR_W'(BASE_OFS));
    assign rgn_limit_wsel[g] = wr_en && (wr_addr == ADDR_W'(LIMIT_OFS));
    assign rgn_base_rsel[g]  = (rd_addr == ADDR_W'(BASE_OFS));
    assign rgn_limit_rsel[g] = (rd_addr == ADDR_W'(LIMIT_OFS));

    always_ff @(posedge i_sys_clk)
    begin
      if (!i_rst_n)
      begin
        rgn_base_q[g]  <= RST_RGN;
        rgn_limit_q[g] <= RST_RGN;
      end
      else
      begin
        if (rgn_base_wsel[g])
          rgn_base_q[g] <= (rgn_base_q[g] & ~bmask) | (wr_data & bmask);
        if (rgn_limit_wsel[g])
          rgn_limit_q[g] <= (rgn_limit_q[g] & ~bmask) | (wr_data & bmask);
      end
    end
  end

  always_comb
  begin
    rgn_rdata = '0;
    for (int i = 0; i < N_RGN; i++)
    begin
      if (rgn_base_rsel[i])
        rgn_rdata = rgn_base_q[i];
      if (rgn_limit_rsel[i])
        rgn_rdata = rgn_limit_q[i];
    end
  end

  // A clear is a one written to the clear bit through its byte lane.
  assign clear_req = wsel_clear && wr_strb[0] && wr_data[CLR_POS];

  assign violation = i_acc_valid && ctrl_q[CTRL_EN_POS] && (i_acc_kind == KIND_WRITE)
                     && rgn_hit;
  assign o_acc_deny = violation;

  // A violation in the clearing cycle is captured, so the set wins over the clear.
  assign capture = violation && ((state_q == CFGFLT_ARMED) || clear_req);
  assign lost    = violation && !capture;

  always_comb
  begin
    new_stat = '0;
    new_stat[FS_ORIG_LO_POS +: FS_ORIG_LO_W] = i_acc_id[FS_ORIG_LO_W-1:0];
    new_stat[FS_ORIG_HI_POS +: FS_ORIG_HI_W] = i_acc_id[ORIG_W-1:FS_ORIG_LO_W];
    new_stat[FS_LOCAL_POS] = i_acc_local;
    new_stat[FS_SUP_READ_POS] = i_acc_super && (i_acc_kind == KIND_READ);
    new_stat[FS_SUP_WRITE_POS] = i_acc_super && (i_acc_kind == KIND_WRITE);
    new_stat[FS_SUP_EXEC_POS] = i_acc_super && (i_acc_kind == KIND_EXEC);
    new_stat[FS_USR_READ_POS] = !i_acc_super && (i_acc_kind == KIND_READ);
    new_stat[FS_USR_WRITE_POS] = !i_acc_super && (i_acc_kind == KIND_WRITE);
    new_stat[FS_USR_EXEC_POS] = !i_acc_super && (i_acc_kind == KIND_EXEC);
  end

  always_comb
  begin
    case (state_q)
      CFGFLT_ARMED:
        state_d = capture ? CFGFLT_HELD : CFGFLT_ARMED;
      CFGFLT_HELD:
        state_d = (clear_req && !capture) ? CFGFLT_ARMED : CFGFLT_HELD;
      default:
        state_d = CFGFLT_ARMED;
    endcase
  end

  // Capture registers change only on capture or clear, never on a read.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_q      <= CFGFLT_ARMED;
      fault_addr_q <= RST_FAULT_ADDR;
      fault_stat_q <= RST_FAULT_STATUS;
      o_fault_exc  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      o_fault_exc <= capture;
      if (capture)
      begin
        fault_addr_q <= i_acc_addr;
        fault_stat_q <= new_stat;
      end
      else if (clear_req)
      begin
        fault_addr_q <= RST_FAULT_ADDR;
        fault_stat_q <= RST_FAULT_STATUS;
      end
    end
  end

  // Sticky event bits; a new event in the clearing cycle stays set.
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (wsel_irq_stat && wr_strb[0])
      irq_stat_d = irq_stat_q & ~wr_data[IRQ_W-1:0];
    irq_stat_d[IRQ_CAPT_POS] = irq_stat_d[IRQ_CAPT_POS] | capture;
    irq_stat_d[IRQ_LOST_POS] = irq_stat_d[IRQ_LOST_POS] | lost;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      irq_stat_q <= RST_IRQ;
      irq_mask_q <= RST_IRQ;
      ctrl_q     <= RST_CTRL;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (wsel_irq_mask && wr_strb[0])
        irq_mask_q <= wr_data[IRQ_W-1:0];
      if (wsel_ctrl)
        ctrl_q <= (ctrl_q & ~bmask) | (wr_data & bmask);
    end
  end

  // Level output; the capture bit fires once per series of faults, the lost bit on its later faults.
  assign o_prot_fault_irq = |(irq_stat_q & irq_mask_q);

  // Read data mux; reads have no side effects.
  assign rsel_fixed = (rd_addr == ADDR_W'(OFS_FAULT_ADDR))
                      || (rd_addr == ADDR_W'(OFS_FAULT_STATUS))
                      || (rd_addr == ADDR_W'(OFS_CLEAR))
                      || (rd_addr == ADDR_W'(OFS_IRQ_STATUS))
                      || (rd_addr == ADDR_W'(OFS_IRQ_MASK))
                      || (rd_addr == ADDR_W'(OFS_CTRL));
  assign rd_err = rd_en && !(rsel_fixed || (|rgn_base_rsel) || (|rgn_limit_rsel));

  always_comb
  begin
    case (rd_addr)
      ADDR_W'(OFS_FAULT_ADDR):   rd_data = fault_addr_q;
      ADDR_W'(OFS_FAULT_STATUS): rd_data = fault_stat_q;
      ADDR_W'(OFS_IRQ_STATUS):   rd_data = {{(32-IRQ_W){1'b0}}, irq_stat_q};
      ADDR_W'(OFS_IRQ_MASK):     rd_data = {{(32-IRQ_W){1'b0}}, irq_mask_q};
      ADDR_W'(OFS_CTRL):         rd_data = ctrl_q;
      default:                   rd_data = rgn_rdata;
    endcase
  end

endmodule

// ---- verification/cfgflt_asserts.sv ----
// Purpose: Port-level assertions for the fault capture block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Held state is rebuilt from the ports and re-armed early by a clear write.
`timescale 1ns/10ps
module cfgflt_chk
  import cfgflt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // Register bus
  input  wire logic              i_axi_awvalid,
  input  wire logic              o_axi_awready,
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_wvalid,
  input  wire logic              o_axi_wready,
  input  wire logic              o_axi_bvalid,
  input  wire logic              i_axi_arvalid,
  input  wire logic              o_axi_arready,
  input  wire logic              o_axi_rvalid,
  input  wire logic              i_axi_rready,
  input  wire logic [31:0]       o_axi_rdata,
  // Access side
  input  wire logic              i_acc_valid,
  input  wire logic [1:0]        i_acc_kind,
  input  wire logic              o_acc_deny,
  input  wire logic              o_fault_exc
);
  logic      held_q;
  wire logic aw_clr  = i_axi_awvalid && o_axi_awready && (i_axi_awaddr == OFS_CLEAR);
  wire logic wr_take = i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Re-arming on the address phase is early, which makes the series check lenient and can fail a_rearm_exc on a violation before the clear lands.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || aw_clr)
      held_q <= 1'b0;
    else if (o_fault_exc)
      held_q <= 1'b1;
  end
  a_deny_on_write:
    assert property (o_acc_deny |-> i_acc_valid && i_acc_kind == KIND_WRITE)
      else $error("deny without a write access");
  a_exc_after_deny:
    assert property (o_fault_exc |-> $past(o_acc_deny))
      else $error("exception without a denied access");
  a_exc_one_pulse:
    assert property (o_fault_exc |=> !o_fault_exc [*2])
      else $error("exception longer than one cycle");
  a_one_exc_series:
    assert property (o_fault_exc |-> !held_q)
      else $error("second exception before clear");
  a_rearm_exc:
    assert property (o_acc_deny && !held_q && !o_fault_exc |=> o_fault_exc)
      else $error("armed violation gave no exception");
  a_write_resp:
    assert property (wr_take |-> ##2 o_axi_bvalid)
      else $error("write response late");
  a_read_answer:
    assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
      else $error("read answer late");
  a_rdata_stand:
    assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read data changed while waiting");
endmodule

// ---- verification/cfgflt_acc_master.sv ----
// Purpose: Behavioural initiator issuing configuration-space accesses.
// Assumes: One-cycle strobes launched just after a rising clock edge.
// Notes:   Released fields show the inverse of the last value, never a stale copy.
`timescale 1ns/10ps
module cfgflt_acc_master
  import cfgflt_pkg::*;
(
  // Clock
  input  wire logic         i_sys_clk,
  // Access strobe
  output logic              o_acc_valid,
  output logic [31:0]       o_acc_addr,
  output logic [1:0]        o_acc_kind,
  output logic              o_acc_super,
  output logic              o_acc_local,
  output logic [ORIG_W-1:0] o_acc_id
);
  initial
  begin
    o_acc_valid = 1'b0;
    o_acc_addr  = 32'h0000_0000;
    o_acc_kind  = KIND_READ;
    o_acc_super = 1'b0;
    o_acc_local = 1'b0;
    o_acc_id    = 7'h00;
  end
  // A gap of zero still leaves an idle cycle, so each strobe stays a single cycle.
  task automatic issue(input logic [31:0] a, input logic [1:0] k, input logic s,
                       input logic l, input logic [ORIG_W-1:0] id, input int gap);
    repeat (gap + 1) @(posedge i_sys_clk);
    o_acc_valid <= 1'b1;
    o_acc_addr  <= a;
    o_acc_kind  <= k;
    o_acc_super <= s;
    o_acc_local <= l;
    o_acc_id    <= id;
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b0;
    o_acc_addr  <= ~a;
    o_acc_kind  <= ~k;
    o_acc_super <= ~s;
    o_acc_local <= ~l;
    o_acc_id    <= ~id;
  endtask
endmodule

// ---- verification/cfgflt_top_tb.sv ----
// Purpose: Self-checking bench for the configuration-space fault capture block.
// Assumes: Writes offer address and data together; one access initiator.
// Notes:   Deny and exception cycles are counted by a monitor.
`timescale 1ns/10ps
module cfgflt_top_tb
  import cfgflt_pkg::*;
();
  logic             clk, rst_n, awv, wv, br, arv, rr;
  logic [7:0]       awa, ara;
  logic [31:0]      wd;
  wire logic        awr, wrdy, bv, arr, rv, deny, exc, irq, a_v, a_s, a_l;
  wire logic [1:0]  bresp, rresp, a_k;
  wire logic [31:0] rd, a_a;
  wire logic [6:0]  a_id;
  int               n_errors, n_compared, n_deny, n_exc, cyc;
  cfgflt_top #(.ADDR_W(8), .N_RGN(2)) u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wrdy), .i_axi_wdata(wd),
    .i_axi_wstrb(4'hF), .o_axi_bvalid(bv), .i_axi_bready(br), .o_axi_bresp(bresp),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara), .o_axi_rvalid(rv),
    .i_axi_rready(rr), .o_axi_rdata(rd), .o_axi_rresp(rresp), .i_acc_valid(a_v),
    .i_acc_addr(a_a), .i_acc_kind(a_k), .i_acc_super(a_s), .i_acc_local(a_l),
    .i_acc_id(a_id), .o_acc_deny(deny), .o_fault_exc(exc), .o_prot_fault_irq(irq));
  cfgflt_acc_master u_mst (.i_sys_clk(clk), .o_acc_valid(a_v), .o_acc_addr(a_a),
    .o_acc_kind(a_k), .o_acc_super(a_s), .o_acc_local(a_l), .o_acc_id(a_id));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    n_deny += (deny === 1'b1);
    n_exc += (exc === 1'b1);
    if (cyc == 3000)
    begin
      n_errors++;
      $display("Error run_length expected below 3000 seen 3000");
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wchk(input string n, input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= v;
    while (!(ad && dd))
    begin
      @(posedge clk);
      ad = ad || (awr === 1'b1);
      dd = dd || (wrdy === 1'b1);
      awv <= !ad;
      wv <= !dd;
    end
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    chk({n, "_resp"}, {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
    chk(n, e, rd);
    chk({n, "_resp"}, {30'h0, er}, {30'h0, rresp});
  endtask
  // Only writes are violations, so of the six access flags just the write flags rise.
  function automatic logic [31:0] fs(input logic [6:0] id, input logic l, input logic s);
    return {16'h0000, id[6:3], 1'h0, id[2:0], l, 2'h0, s, 2'h0, ~s, 1'h0};
  endfunction
  task automatic t_reset();
    rchk("fault_addr", OFS_FAULT_ADDR, 32'h0000_0000, RESP_OKAY);
    rchk("fault_status", OFS_FAULT_STATUS, 32'h0000_0000, RESP_OKAY);
    rchk("unmapped", 8'h40, 32'h0000_0000, RESP_SLVERR);
    wchk("ro_addr", OFS_FAULT_ADDR, 32'hFFFF_FFFF, RESP_SLVERR);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("test reset done");
  endtask
  task automatic t_first();
    wchk("base0", OFS_RGN_BASE0, 32'h0000_1000, RESP_OKAY);
    wchk("limit0", OFS_RGN_LIMIT0, 32'h0000_10FF, RESP_OKAY);
    wchk("ctrl", OFS_CTRL, 32'h0000_0101, RESP_OKAY);
    wchk("mask", OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    u_mst.issue(32'h0000_10FF, KIND_READ, 1'b0, 1'b1, 7'h5A, 0);
    u_mst.issue(32'h0000_1000, KIND_EXEC, 1'b1, 1'b1, 7'h5A, 0);
    u_mst.issue(32'h0000_1100, KIND_WRITE, 1'b0, 1'b1, 7'h5A, 0);
    u_mst.issue(32'h0000_0FFF, KIND_WRITE, 1'b0, 1'b1, 7'h5A, 0);
    u_mst.issue(32'h0000_10FF, KIND_WRITE, 1'b0, 1'b1, 7'h5A, 2);
    u_mst.issue(32'h0000_1000, KIND_WRITE, 1'b1, 1'b0, 7'h25, 0);
    repeat (3) @(posedge clk);
    chk("deny_count", 32'h0000_0002, n_deny);
    chk("exc_count", 32'h0000_0001, n_exc);
    rchk("fault_addr", OFS_FAULT_ADDR, 32'h0000_10FF, RESP_OKAY);
    rchk("status", OFS_FAULT_STATUS, fs(7'h5A, 1'b1, 1'b0), RESP_OKAY);
    rchk("status_again", OFS_FAULT_STATUS, fs(7'h5A, 1'b1, 1'b0), RESP_OKAY);
    rchk("irq_status", OFS_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    $display("test first fault done");
  endtask
  task automatic t_rearm();
    wchk("clear", OFS_CLEAR, 32'h0000_0001, RESP_OKAY);
    rchk("cleared_addr", OFS_FAULT_ADDR, 32'h0000_0000, RESP_OKAY);
    rchk("cleared_status", OFS_FAULT_STATUS, 32'h0000_0000, RESP_OKAY);
    wchk("irq_w1c", OFS_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
    wchk("mask_off", OFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    u_mst.issue(32'h0000_1080, KIND_WRITE, 1'b1, 1'b0, 7'h37, 0);
    repeat (3) @(posedge clk);
    chk("exc_count", 32'h0000_0002, n_exc);
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    rchk("fault_addr", OFS_FAULT_ADDR, 32'h0000_1080, RESP_OKAY);
    rchk("fault_status", OFS_FAULT_STATUS, fs(7'h37, 1'b0, 1'b1), RESP_OKAY);
    wchk("mask_on", OFS_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    chk("irq_unmasked", 32'h0000_0001, {31'h0, irq});
    wchk("irq_w1c", OFS_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    chk("irq_cleared", 32'h0000_0000, {31'h0, irq});
    $display("test rearm done");
  endtask
  initial
  begin
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0000_0000;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_first();
    t_rearm();
    wrap_up();
  end
endmodule
bind cfgflt_top cfgflt_chk #(.ADDR_W(ADDR_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_axi_awvalid(i_axi_awvalid),
  .o_axi_awready(o_axi_awready), .i_axi_awaddr(i_axi_awaddr), .i_axi_wvalid(i_axi_wvalid),
  .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid), .i_axi_arvalid(i_axi_arvalid),
  .o_axi_arready(o_axi_arready), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
  .o_axi_rdata(o_axi_rdata), .i_acc_valid(i_acc_valid), .i_acc_kind(i_acc_kind),
  .o_acc_deny(o_acc_deny), .o_fault_exc(o_fault_exc));
